//--- hw/rmsl_listen.sv
`include "rmsl_params.svh"
// listen timer on the rc clock: counts windows, reports phase as toggles
module rmsl_listen
(
  input wire logic rc_clk_in,
  input wire logic rc_reset_in,
  input wire logic run_in,
  input wire logic [1:0] idle_unit_in,
  input wire logic [1:0] rx_unit_in,
  input wire logic [7:0] idle_mult_in,
  input wire logic [7:0] rx_mult_in,
  input wire logic trim_req_in,
  output logic in_rx_out,
  output logic trim_busy_out
);
  logic run_s;
  logic trim_s;
  logic trim_prev_q;
  logic [19:0] unit_q;
  logic [7:0] mult_q;
  logic [7:0] trim_q;
  logic [1:0] cur_unit;
  logic [7:0] cur_mult;
  logic [19:0] unit_len;
  logic unit_end;
  logic win_end;
  logic res_ok;
  // unit code to rc tick count
  function automatic logic [19:0] unit_ticks(input logic [1:0] code);
    unit_ticks = (code == `RMSL_RES_01) ? `RMSL_UNIT_01 :
                 (code == `RMSL_RES_10) ? `RMSL_UNIT_10 : `RMSL_UNIT_11;
  endfunction : unit_ticks
  rmsl_sync u_run (.clk_in(rc_clk_in), .reset_in(rc_reset_in), .d_in(run_in), .q_out(run_s));
  rmsl_sync u_trim (.clk_in(rc_clk_in), .reset_in(rc_reset_in), .d_in(trim_req_in),
    .q_out(trim_s));
  // next window takes the settings of the other phase
  assign cur_unit = in_rx_out ? idle_unit_in : rx_unit_in;
  assign cur_mult = in_rx_out ? idle_mult_in : rx_mult_in;
  assign unit_len = unit_ticks(cur_unit);
  // reserved unit 00 blocks timing in either window
  assign res_ok = (idle_unit_in != `RMSL_RES_RSVD) && (rx_unit_in != `RMSL_RES_RSVD);
  assign unit_end = (unit_q == 20'h00001);
  assign win_end = unit_end && (mult_q == 8'h01);
  // window counters reload at every window start
  always_ff @(posedge rc_clk_in)
  begin
    if (rc_reset_in || !run_s || !res_ok)
    begin
      unit_q <= `RMSL_UNIT_01;
      mult_q <= 8'h01;
      in_rx_out <= 1'b1;
    end
    else if (win_end)
    begin
      unit_q <= unit_len;
      mult_q <= (cur_mult == 8'h00) ? 8'h01 : cur_mult;
      in_rx_out <= !in_rx_out;
    end
    else if (unit_end)
    begin
      unit_q <= in_rx_out ? unit_ticks(rx_unit_in) : unit_ticks(idle_unit_in);
      mult_q <= mult_q - 8'h01;
    end
    else
    begin
      unit_q <= unit_q - 20'h00001;
    end
  end
  // rc trim at power-up and on request
  always_ff @(posedge rc_clk_in)
  begin
    if (rc_reset_in)
    begin
      trim_q <= `RMSL_TRIM_TICKS;
      trim_prev_q <= 1'b0;
    end
    else
    begin
      trim_prev_q <= trim_s;
      if (trim_s && !trim_prev_q)
        trim_q <= `RMSL_TRIM_TICKS;
      else if (trim_q != 8'h00)
        trim_q <= trim_q - 8'h01;
    end
  end
  assign trim_busy_out = (trim_q != 8'h00);
endmodule : rmsl_listen

//--- hw/rmsl_params.svh
`ifndef RMSL_PARAMS_SVH
`define RMSL_PARAMS_SVH
// system clock rate in kHz
`define RMSL_CLK_KHZ 50000
// fixed part of the transmit start-up delay, in ns
`define RMSL_TX_FIXED_NS 5000
`define RMSL_TX_FIXED_CYC ((`RMSL_TX_FIXED_NS * `RMSL_CLK_KHZ + 999999) / 1000000)
// power-amp rise scale 1.25 written as 5/4
`define RMSL_RISE_NUM 5
`define RMSL_RISE_DEN 4
// analog front-end group delay, in ns
`define RMSL_TANA_NS 20000
`define RMSL_TANA_CYC ((`RMSL_TANA_NS * `RMSL_CLK_KHZ + 999999) / 1000000)
// channel filter numerators, over four times the filter width
`define RMSL_TCF_FSK 21
`define RMSL_TCF_OOK 34
`define RMSL_TCF_DIV 4
// pll relock allowance: 5 over a 300 kHz loop bandwidth
`define RMSL_PLL_NUM 5
`define RMSL_PLL_BW_KHZ 300
`define RMSL_PLL_CYC ((`RMSL_PLL_NUM * `RMSL_CLK_KHZ + `RMSL_PLL_BW_KHZ - 1) / `RMSL_PLL_BW_KHZ)
// frequency correction window in bit periods
`define RMSL_AFC_BITS 4
// signal strength sample scale
`define RMSL_RSSI_MUL 2
// preamble bits for bit-sync lock
`define RMSL_LOCK_BITS 12
// receive timeout granularity in bit periods
`define RMSL_TMO_BITS 16
// listen units in rc ticks; the rc tick is taken as 1 us here
`define RMSL_UNIT_01 20'h00040
`define RMSL_UNIT_10 20'h01004
`define RMSL_UNIT_11 20'h3ff7c
// listen unit codes
`define RMSL_RES_RSVD 2'h0
`define RMSL_RES_01 2'h1
`define RMSL_RES_10 2'h2
`define RMSL_RES_11 2'h3
// end of cycle actions
`define RMSL_END_STAY 2'h0
`define RMSL_END_MODE 2'h1
`define RMSL_END_IDLE 2'h2
// rc trim duration in rc ticks
`define RMSL_TRIM_TICKS 8'h20
`endif

//--- hw/rmsl_pkg.sv
package rmsl_pkg;
  // basic mode field encodings
  typedef enum logic [2:0]
  {
    RMSL_SLEEP = 3'h0,
    RMSL_STBY = 3'h1,
    RMSL_SYNTH = 3'h2,
    RMSL_TX = 3'h3,
    RMSL_RX = 3'h4
  } rmsl_mode_e;
  // listen phases
  typedef enum logic [1:0]
  {
    RMSL_L_OFF,
    RMSL_L_IDLE,
    RMSL_L_RX,
    RMSL_L_HOLD
  } rmsl_listen_e;
endpackage : rmsl_pkg

//--- hw/rmsl_sync.sv
// two-flop level synchroniser
module rmsl_sync
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta_q;
  // first flop feeds only the second
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      meta_q <= 1'b0;
      q_out <= 1'b0;
    end
    else
    begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule : rmsl_sync

//--- hw/rmsl_top.sv
`include "rmsl_params.svh"
// Function
// - tx delay 5us, 1.25 rise (fsk only), half bit
// - packet preamble starts on settled flag
// - rx budget: 20us plus filter delay
// - relock allowance five over 300kHz
// - correction window four bit periods
// - signal sample twice int term over bandwidth
// - bit sync needs 12 preamble bits
// - no bit sync: data right after settled
// - listen idles, wakes receiver, keeps on signal
// - no signal: receiver off until next receive window
// - window equals multiplier times unit code
// - multiplier 1 to 255 per window
// - receive window includes wake-up time
// - accept on level, optionally sync match
// - end actions stay, go mode, resume idle
// - rc trim at power-up and on request
// - auto mode hops to transit and back
// - mode rewrite in transit ends the hop at once
// - mode codes sleep to receive
// - rx timeout after count times 16 bits
module rmsl_top
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic rc_clk_in,
  input wire logic [2:0] mode_in,
  input wire logic listen_enable_in,
  input wire logic listen_abort_bit_in,
  input wire logic auto_sequence_disable_in,
  input wire logic ook_in,
  input wire logic packet_mode_in,
  input wire logic bit_sync_on_in,
  input wire logic [15:0] bit_cycles_in,
  input wire logic [15:0] power_amp_rise_time_in,
  input wire logic [15:0] receive_filter_width_in,
  input wire logic [7:0] rx_start_timeout_count_in,
  input wire logic transmit_trigger_in,
  input wire logic [1:0] idle_unit_in,
  input wire logic [1:0] rx_unit_in,
  input wire logic [7:0] idle_mult_in,
  input wire logic [7:0] rx_mult_in,
  input wire logic listen_accept_rule_in,
  input wire logic [1:0] listen_end_action_in,
  input wire logic level_hit_in,
  input wire logic sync_match_flag_in,
  input wire logic payload_complete_flag_in,
  input wire logic rc_trim_start_in,
  input wire logic auto_enable_in,
  input wire logic [2:0] transit_mode_in,
  input wire logic entry_trigger_in,
  input wire logic leave_trigger_in,
  input wire logic demod_bit_in,
  input wire logic preamble_bit_in,
  output logic [2:0] active_mode_out,
  output logic mode_settled_flag_out,
  output logic transmit_settled_flag_out,
  output logic receive_settled_flag_out,
  output logic preamble_on_out,
  output logic packet_start_out,
  output logic sync_locked_out,
  output logic rx_timeout_out,
  output logic rc_trim_done_out,
  output logic listen_rx_on_out,
  output logic serial_data_pin_out,
  output logic serial_clock_pin_out,
  output logic buffer_flush_out
);
  ////////////////////////////////////////////////////////////////////////////
  // pin inputs from the link, all but the preamble bit, pass two flops
  logic trig_s;
  logic level_s;
  logic match_s;
  logic payload_s;
  logic demod_s;
  logic rc_rx_s;
  logic rc_done_s;
  logic rc_rx_raw;
  logic rc_busy_raw;
  logic rc_done_raw;
  rmsl_sync u_s0 (.clk_in(clk_in), .reset_in(reset_in), .d_in(transmit_trigger_in),
    .q_out(trig_s));
  rmsl_sync u_s1 (.clk_in(clk_in), .reset_in(reset_in), .d_in(level_hit_in), .q_out(level_s));
  rmsl_sync u_s2 (.clk_in(clk_in), .reset_in(reset_in), .d_in(sync_match_flag_in),
    .q_out(match_s));
  rmsl_sync u_s3 (.clk_in(clk_in), .reset_in(reset_in), .d_in(payload_complete_flag_in),
    .q_out(payload_s));
  rmsl_sync u_s4 (.clk_in(clk_in), .reset_in(reset_in), .d_in(demod_bit_in), .q_out(demod_s));
  rmsl_sync u_s5 (.clk_in(clk_in), .reset_in(reset_in), .d_in(rc_rx_raw), .q_out(rc_rx_s));
  rmsl_sync u_s6 (.clk_in(clk_in), .reset_in(reset_in), .d_in(rc_done_raw), .q_out(rc_done_s));
  ////////////////////////////////////////////////////////////////////////////
  // listen timer in the rc domain
  logic rc_reset;
  // done is carried across, not busy, so the synchroniser's reset value reads as not done
  assign rc_done_raw = !rc_busy_raw;
  logic listen_run_q;
  rmsl_sync u_rcr (.clk_in(rc_clk_in), .reset_in(1'b0), .d_in(reset_in), .q_out(rc_reset));
  rmsl_listen u_listen
  (
    .rc_clk_in(rc_clk_in),
    .rc_reset_in(rc_reset),
    .run_in(listen_run_q),
    .idle_unit_in(idle_unit_in),
    .rx_unit_in(rx_unit_in),
    .idle_mult_in(idle_mult_in),
    .rx_mult_in(rx_mult_in),
    .trim_req_in(rc_trim_start_in),
    .in_rx_out(rc_rx_raw),
    .trim_busy_out(rc_busy_raw)
  );
  ////////////////////////////////////////////////////////////////////////////
  // start-up delay computations
  logic [31:0] half_bit;
  logic [31:0] tx_delay;
  logic [31:0] tcf_cyc;
  logic [31:0] rssi_cyc;
  logic [31:0] rx_delay;
  logic [31:0] bsync_cyc;
  logic [31:0] tmo_cyc;
  logic [31:0] filt4;
  logic [47:0] bwt;
  assign half_bit = {17'h00000, bit_cycles_in[15:1]};
  // tx: fixed + 1.25 rise (fsk only) + half bit, rise given in cycles
  assign tx_delay = 32'(`RMSL_TX_FIXED_CYC) + half_bit + (ook_in ? 32'h0 :
    32'((32'(power_amp_rise_time_in) * `RMSL_RISE_NUM + `RMSL_RISE_DEN - 1) / `RMSL_RISE_DEN));
  // filter width in khz; four times it is the divisor
  assign filt4 = 32'(`RMSL_TCF_DIV) * 32'((receive_filter_width_in == 16'h0000) ? 16'h0001 :
    receive_filter_width_in);
  assign tcf_cyc = 32'(((ook_in ? `RMSL_TCF_OOK : `RMSL_TCF_FSK) * `RMSL_CLK_KHZ + filt4 - 1)
    / filt4);
  // integer part of 4*bw*tbit: bw khz times cycles over clock khz
  assign bwt = 48'(filt4) * 48'(bit_cycles_in) / 48'(`RMSL_CLK_KHZ);
  assign rssi_cyc = 32'((48'(`RMSL_RSSI_MUL) * bwt * 48'(`RMSL_CLK_KHZ) + 48'(filt4) - 48'h1)
    / 48'(filt4));
  // receive budget: front end, filter, relock, correction window, sample
  assign rx_delay = 32'(`RMSL_TANA_CYC) + tcf_cyc + 32'(`RMSL_PLL_CYC)
    + 32'(`RMSL_AFC_BITS) * 32'(bit_cycles_in) + rssi_cyc;
  assign bsync_cyc = 32'(`RMSL_LOCK_BITS) * 32'(bit_cycles_in);
  assign tmo_cyc = 32'(`RMSL_TMO_BITS) * 32'(bit_cycles_in) * 32'(rx_start_timeout_count_in);
  ////////////////////////////////////////////////////////////////////////////
  // mode selection and listen control
  rmsl_pkg::rmsl_listen_e lst_q;
  rmsl_pkg::rmsl_listen_e lst_d;
  logic [2:0] target_q;
  logic in_transit_q;
  logic [2:0] mode_prev_q;
  logic rc_rx_prev_q;
  logic accept;
  logic hold_done;
  logic [2:0] want_mode;
  logic mode_change;
  logic settled_rx_q;
  // acceptance: level always, sync match when the rule is 1
  assign accept = level_s && (!listen_accept_rule_in || match_s);
  assign hold_done = payload_s || rx_timeout_out;
  // listen phase machine
  always_comb
  begin
    lst_d = lst_q;
    unique case (lst_q)
      rmsl_pkg::RMSL_L_OFF:
        if (listen_enable_in && !listen_abort_bit_in && active_mode_out == rmsl_pkg::RMSL_STBY)
          lst_d = rmsl_pkg::RMSL_L_IDLE;
      rmsl_pkg::RMSL_L_IDLE:
        if (rc_rx_s && !rc_rx_prev_q)
          lst_d = rmsl_pkg::RMSL_L_RX;
      rmsl_pkg::RMSL_L_RX:
        if (settled_rx_q && accept)
          lst_d = rmsl_pkg::RMSL_L_HOLD;
        else if (!rc_rx_s)
          lst_d = rmsl_pkg::RMSL_L_IDLE;
      rmsl_pkg::RMSL_L_HOLD:
        if (listen_end_action_in == `RMSL_END_IDLE && hold_done)
          lst_d = rmsl_pkg::RMSL_L_IDLE;
    endcase
    if (!listen_enable_in || listen_abort_bit_in)
      lst_d = rmsl_pkg::RMSL_L_OFF;
  end
  // host mode writes and the listen end action choose the target
  assign mode_change = (mode_in != mode_prev_q);
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      lst_q <= rmsl_pkg::RMSL_L_OFF;
      rc_rx_prev_q <= 1'b0;
      mode_prev_q <= 3'h1;
      target_q <= 3'h1;
      in_transit_q <= 1'b0;
      buffer_flush_out <= 1'b0;
      listen_run_q <= 1'b0;
    end
    else
    begin
      lst_q <= lst_d;
      // the rc timer runs whenever listen is active
      listen_run_q <= (lst_d != rmsl_pkg::RMSL_L_OFF);
      rc_rx_prev_q <= rc_rx_s;
      mode_prev_q <= mode_in;
      // flush the buffer whenever listen moves from idle into a receive window
      buffer_flush_out <= (lst_q == rmsl_pkg::RMSL_L_IDLE) && (lst_d == rmsl_pkg::RMSL_L_RX);
      if (lst_q != rmsl_pkg::RMSL_L_OFF)
      begin
        // detection with end action 01 leaves receive for the written mode
        if (lst_q == rmsl_pkg::RMSL_L_HOLD && listen_end_action_in == `RMSL_END_MODE && hold_done)
          target_q <= mode_in;
        else if (lst_q == rmsl_pkg::RMSL_L_HOLD || lst_q == rmsl_pkg::RMSL_L_RX)
          target_q <= rmsl_pkg::RMSL_RX;
        else
          target_q <= rmsl_pkg::RMSL_STBY;
      end
      else if (auto_enable_in && !in_transit_q && entry_trigger_in)
      begin
        target_q <= transit_mode_in;
        in_transit_q <= 1'b1;
      end
      else if (in_transit_q && mode_change)
      begin
        target_q <= mode_in;
        in_transit_q <= 1'b0;
      end
      else if (in_transit_q && leave_trigger_in)
      begin
        target_q <= mode_in;
        in_transit_q <= 1'b0;
      end
      else if (!in_transit_q)
        target_q <= (mode_in > 3'h4) ? 3'h1 : mode_in;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // start-up timing and settled flags
  logic [31:0] wait_q;
  logic [31:0] rxt_q;
  logic seen_level_q;
  logic [31:0] bs_q;
  logic [15:0] bclk_q;
  assign want_mode = target_q;
  // delay counter restarts on every mode change
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      active_mode_out <= 3'h1;
      wait_q <= 32'h0;
      mode_settled_flag_out <= 1'b0;
      transmit_settled_flag_out <= 1'b0;
      receive_settled_flag_out <= 1'b0;
      settled_rx_q <= 1'b0;
    end
    else if (want_mode != active_mode_out)
    begin
      active_mode_out <= want_mode;
      // without the sequencer the mode is taken at once
      wait_q <= auto_sequence_disable_in ? 32'h0 :
        (want_mode == rmsl_pkg::RMSL_TX) ? tx_delay :
        (want_mode == rmsl_pkg::RMSL_RX) ? rx_delay : 32'h0;
      mode_settled_flag_out <= 1'b0;
      transmit_settled_flag_out <= 1'b0;
      receive_settled_flag_out <= 1'b0;
      settled_rx_q <= 1'b0;
    end
    else if (wait_q != 32'h0)
      wait_q <= wait_q - 32'h1;
    else
    begin
      mode_settled_flag_out <= 1'b1;
      transmit_settled_flag_out <= (active_mode_out == rmsl_pkg::RMSL_TX);
      receive_settled_flag_out <= (active_mode_out == rmsl_pkg::RMSL_RX);
      settled_rx_q <= (active_mode_out == rmsl_pkg::RMSL_RX);
    end
  end
  // packet preamble and triggered packet start
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      preamble_on_out <= 1'b0;
      packet_start_out <= 1'b0;
    end
    else
    begin
      preamble_on_out <= packet_mode_in && (transmit_settled_flag_out ||
        (mode_settled_flag_out && active_mode_out == rmsl_pkg::RMSL_TX));
      packet_start_out <= preamble_on_out && trig_s;
    end
  end
  // receive timeout and bit-sync lock counters
  always_ff @(posedge clk_in)
  begin
    if (reset_in || active_mode_out != rmsl_pkg::RMSL_RX)
    begin
      rxt_q <= 32'h0;
      seen_level_q <= 1'b0;
      rx_timeout_out <= 1'b0;
      bs_q <= 32'h0;
      sync_locked_out <= 1'b0;
    end
    else
    begin
      seen_level_q <= seen_level_q || level_s;
      rxt_q <= rxt_q + 32'h1;
      // timeout fires only while the level has not risen
      rx_timeout_out <= !seen_level_q && !level_s && (rx_start_timeout_count_in != 8'h00)
        && (rxt_q == tmo_cyc);
      if (receive_settled_flag_out && bs_q < bsync_cyc)
        bs_q <= bs_q + 32'h1;
      sync_locked_out <= receive_settled_flag_out &&
        (!bit_sync_on_in || bs_q >= bsync_cyc);
    end
  end
  // serial pins: bit clock in tx, data in rx once valid
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      bclk_q <= 16'h0;
      serial_clock_pin_out <= 1'b0;
      serial_data_pin_out <= 1'b0;
      listen_rx_on_out <= 1'b0;
      rc_trim_done_out <= 1'b0;
    end
    else
    begin
      bclk_q <= (bclk_q >= half_bit[15:0]) ? 16'h0 : bclk_q + 16'h1;
      if (transmit_settled_flag_out && bclk_q >= half_bit[15:0])
        serial_clock_pin_out <= !serial_clock_pin_out;
      serial_data_pin_out <= sync_locked_out ? demod_s :
        (transmit_settled_flag_out && preamble_bit_in);
      listen_rx_on_out <= (lst_q == rmsl_pkg::RMSL_L_RX) || (lst_q == rmsl_pkg::RMSL_L_HOLD);
      rc_trim_done_out <= rc_done_s;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // checks on the sequencer
  sequence rmsl_mode_moves;
    want_mode != active_mode_out;
  endsequence
  sequence rmsl_flags_low;
    !mode_settled_flag_out && !transmit_settled_flag_out && !receive_settled_flag_out;
  endsequence
  AST_FLAGS_DROP: assert property (@(posedge clk_in) disable iff (reset_in)
    rmsl_mode_moves |=> rmsl_flags_low) else $error("settled flag kept over mode change");
  AST_TX_FLAG_MODE: assert property (@(posedge clk_in) disable iff (reset_in)
    transmit_settled_flag_out |-> active_mode_out == rmsl_pkg::RMSL_TX)
    else $error("transmit flag outside transmit");
  AST_PREAMBLE_FOLLOWS: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(transmit_settled_flag_out) && packet_mode_in |=> preamble_on_out)
    else $error("preamble not started");
  AST_PACKET_AFTER_PREAMBLE: assert property (@(posedge clk_in) disable iff (reset_in)
    packet_start_out |-> $past(preamble_on_out)) else $error("packet before preamble");
  AST_RX_WINDOW_CLOSE: assert property (@(posedge clk_in) disable iff (reset_in)
    lst_q == rmsl_pkg::RMSL_L_RX && !rc_rx_s && !(settled_rx_q && accept) && listen_enable_in
    && !listen_abort_bit_in |=> lst_q == rmsl_pkg::RMSL_L_IDLE) else $error("receive kept on");
  AST_TIMEOUT_PULSE: assert property (@(posedge clk_in) disable iff (reset_in)
    rx_timeout_out |=> !rx_timeout_out) else $error("timeout longer than a cycle");
  AST_LOCK_BITS: assert property (@(posedge clk_in) disable iff (reset_in)
    sync_locked_out && bit_sync_on_in |-> bs_q >= bsync_cyc) else $error("early lock");
  // hops between tx and rx pass through the normal mode machine
endmodule : rmsl_top

//--- tb/rmsl_host_model.sv
// host side of the serial data link: feeds preamble bits once the transmitter is up
module rmsl_host_model
(
  input wire logic clk_in,
  input wire logic settled_in,
  input wire logic bit_clk_in,
  output logic preamble_bit_out
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  // last seen level of the bit clock, for edge detection
  logic bit_clk_q = 1'b0;
  initial preamble_bit_out = 1'b0;
  ////////////////////////////////////////
  // alternating preamble paced by the bit clock; an unused line keeps moving
  // so a stale value can never pass for real data
  always @(posedge clk_in)
  begin
    bit_clk_q <= bit_clk_in;
    if (!settled_in)
      preamble_bit_out <= ~preamble_bit_out; // line not in use
    else if (bit_clk_in && !bit_clk_q)
      preamble_bit_out <= ~preamble_bit_out;
  end
endmodule : rmsl_host_model

//--- tb/rmsl_top_tb_top.sv
// self-checking bench for the mode sequencer and listen timer
module rmsl_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  // design inputs, all given a value at time zero
  logic clk_in = 1'b0, rc_clk_in = 1'b0, reset_in = 1'b1;
  logic [2:0] mode_in = 3'h1, transit_mode_in = 3'h3;
  logic listen_enable_in = 1'b0, listen_abort_bit_in = 1'b0, ook_in = 1'b0;
  logic auto_sequence_disable_in = 1'b0, packet_mode_in = 1'b1, bit_sync_on_in = 1'b0;
  logic [15:0] bit_cycles_in = 16'h0064, power_amp_rise_time_in = 16'h0028;
  logic [15:0] receive_filter_width_in = 16'h03e8;
  logic [7:0] rx_start_timeout_count_in = 8'h02, idle_mult_in = 8'h02, rx_mult_in = 8'h01;
  logic transmit_trigger_in = 1'b0, listen_accept_rule_in = 1'b0;
  logic [1:0] idle_unit_in = 2'h1, rx_unit_in = 2'h1, listen_end_action_in = 2'h0;
  logic level_hit_in = 1'b0, sync_match_flag_in = 1'b0, payload_complete_flag_in = 1'b0;
  logic rc_trim_start_in = 1'b0, auto_enable_in = 1'b0, entry_trigger_in = 1'b0;
  logic leave_trigger_in = 1'b0, demod_bit_in = 1'b0, preamble_bit_in;
  // design outputs
  logic [2:0] active_mode_out;
  logic mode_settled_flag_out, transmit_settled_flag_out, receive_settled_flag_out;
  logic preamble_on_out, packet_start_out, sync_locked_out, rx_timeout_out;
  logic rc_trim_done_out, listen_rx_on_out, serial_data_pin_out, serial_clock_pin_out;
  logic buffer_flush_out;
  // bookkeeping
  int err_total = 0, cmp_count = 0, cyc = 0, n = 0;
  time t0 = 0;
  // mode rows: requested code in [5:3], expected active code in [2:0]
  logic [5:0] rows [6] = '{6'h00, 6'h12, 6'h1b, 6'h24, 6'h39, 6'h09};
  ////////////////////////////////////////
  rmsl_top dut_u (.*);
  rmsl_host_model host_u
  (
    .clk_in(clk_in),
    .settled_in(transmit_settled_flag_out),
    .bit_clk_in(serial_clock_pin_out),
    .preamble_bit_out(preamble_bit_in)
  );
  ////////////////////////////////////////
  // 50 MHz system clock; rc clock at 30 ns, phase offset so three rc edges land in reset
  always #10 clk_in = ~clk_in;
  initial
  begin
    #5;
    forever
    begin
      rc_clk_in = ~rc_clk_in;
      #15;
    end
  end
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // bounded wait; n ends as the count of edges waited
  task automatic wait_for(ref logic sig, input logic lvl, input int lim);
    n = 0;
    while (sig !== lvl && n < lim)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
  endtask : wait_for
  task automatic set_mode(input logic [2:0] m);
    @(posedge clk_in);
    mode_in <= m;
  endtask : set_mode
  // transmit entry: settle delay d in cycles, then preamble and trigger
  task automatic tx_run(input int d);
    set_mode(3'h3);
    wait_for(transmit_settled_flag_out, 1'b1, 2000);
    check(n >= d + 3 && n <= d + 4, 1'b1);
    check(mode_settled_flag_out, 1'b1);
    @(posedge clk_in);
    #1;
    check(preamble_on_out, 1'b1);
    check(packet_start_out, 1'b0);
    @(posedge clk_in);
    transmit_trigger_in <= 1'b1;
    wait_for(packet_start_out, 1'b1, 10);
    check(packet_start_out, 1'b1);
    @(posedge clk_in);
    transmit_trigger_in <= 1'b0;
    set_mode(3'h1);
    repeat (4) @(posedge clk_in);
  endtask : tx_run
  // one trigger pulse of the automatic mode hop
  task automatic auto_step(input logic en, input logic lv);
    @(posedge clk_in);
    entry_trigger_in <= en;
    leave_trigger_in <= lv;
    @(posedge clk_in);
    entry_trigger_in <= 1'b0;
    leave_trigger_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
  endtask : auto_step
  ////////////////////////////////////////
  // hang guard: well above the roughly 12500 cycles the run needs
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_total++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    check(active_mode_out, 3'h1);
    wait_for(rc_trim_done_out, 1'b1, 200);
    check(rc_trim_done_out, 1'b1);
    // plain mode codes; an undefined code falls back to standby
    foreach (rows[i])
    begin
      set_mode(rows[i][5:3]);
      repeat (3) @(posedge clk_in);
      #1;
      check(active_mode_out, {29'h0, rows[i][2:0]});
    end
    repeat (4) @(posedge clk_in);
    tx_run(350);
    // on-off keying drops the rise term: 250 + half of 300
    ook_in <= 1'b1;
    bit_cycles_in <= 16'h012c;
    tx_run(400);
    ook_in <= 1'b0;
    packet_mode_in <= 1'b0;
    bit_cycles_in <= 16'h0064;
    // receive: 1000 front end + 263 filter + 834 relock + 400 window + 200 sample
    set_mode(3'h4);
    t0 = $time;
    wait_for(receive_settled_flag_out, 1'b1, 3000);
    check(n >= 2700 && n <= 2701, 1'b1);
    for (int b = 0; b < 2; b++)
    begin
      @(posedge clk_in);
      demod_bit_in <= (b == 0);
      repeat (5) @(posedge clk_in);
      #1;
      check(serial_data_pin_out, b == 0);
    end
    wait_for(rx_timeout_out, 1'b1, 4000);
    check(($time - t0) / 20 >= 3200 && ($time - t0) / 20 <= 3206, 1'b1);
    @(posedge clk_in);
    #1;
    check(rx_timeout_out, 1'b0);
    // receive hop through synthesizer mode
    set_mode(3'h2);
    set_mode(3'h4);
    repeat (3) @(posedge clk_in);
    #1;
    check(active_mode_out, 3'h4);
    check(receive_settled_flag_out, 1'b0);
    // automatic hops; a rewrite in transit ends the hop at once
    set_mode(3'h1);
    auto_enable_in <= 1'b1;
    auto_step(1'b1, 1'b0);
    check(active_mode_out, 3'h3);
    auto_step(1'b0, 1'b1);
    check(active_mode_out, 3'h1);
    auto_step(1'b1, 1'b0);
    set_mode(3'h2);
    auto_step(1'b0, 1'b1);
    check(active_mode_out, 3'h2);
    // listen: idle 2 x 64 ticks, receive 1 x 64 ticks of 30 ns
    set_mode(3'h1);
    auto_enable_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    listen_enable_in <= 1'b1;
    wait_for(listen_rx_on_out, 1'b1, 1000);
    t0 = $time;
    repeat (4) @(posedge clk_in);
    #1;
    check(active_mode_out, 3'h4);
    @(posedge clk_in);
    idle_mult_in <= 8'h03;
    wait_for(listen_rx_on_out, 1'b0, 1000);
    check($time - t0 >= 1750 && $time - t0 <= 2150, 1'b1);
    t0 = $time;
    repeat (4) @(posedge clk_in);
    #1;
    check(active_mode_out, 3'h1);
    // the new multiplier is picked up when the next idle window loads
    wait_for(listen_rx_on_out, 1'b1, 1000);
    check($time - t0 >= 5600 && $time - t0 <= 5960, 1'b1);
    // level alone is not enough when a sync match is also required
    @(posedge clk_in);
    listen_accept_rule_in <= 1'b1;
    level_hit_in <= 1'b1;
    wait_for(listen_rx_on_out, 1'b0, 1000);
    check(n < 200, 1'b1);
    // a 4100-tick receive window leaves room for the receiver to settle
    @(posedge clk_in);
    listen_accept_rule_in <= 1'b0;
    rx_unit_in <= 2'h2;
    wait_for(listen_rx_on_out, 1'b1, 1000);
    repeat (6500) @(posedge clk_in);
    #1;
    check(listen_rx_on_out, 1'b1);
    check(active_mode_out, 3'h4);
    // two-write abort back to standby
    @(posedge clk_in);
    listen_enable_in <= 1'b0;
    listen_abort_bit_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    listen_abort_bit_in <= 1'b0;
    level_hit_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    #1;
    check(listen_rx_on_out, 1'b0);
    check(active_mode_out, 3'h1);
    // reserved unit code: the timer must never wake the receiver
    @(posedge clk_in);
    rx_unit_in <= 2'h0;
    listen_enable_in <= 1'b1;
    repeat (600) @(posedge clk_in);
    #1;
    check(listen_rx_on_out, 1'b0);
    @(posedge clk_in);
    listen_enable_in <= 1'b0;
    rc_trim_start_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    rc_trim_start_in <= 1'b0;
    #1;
    check(rc_trim_done_out, 1'b0);
    wait_for(rc_trim_done_out, 1'b1, 300);
    check(rc_trim_done_out, 1'b1);
    report_and_stop();
  end
endmodule : rmsl_top_tb_top
